// ==== rtl/lacq_pkg.sv ====
// Package with widths, register map and sequencer encodings of the acquisition core
package lacq_pkg;
    // Channel widths and memory depth
    localparam int LACQ_REC_W = 47;
    localparam int LACQ_STORE_W = 44;
    localparam int LACQ_BASE_STORE_W = 28;
    localparam int LACQ_BASE_REC_W = 31;
    localparam int LACQ_TIM_W = 8;
    localparam int LACQ_DEPTH = 256;
    localparam int LACQ_AW = 8;
    localparam int LACQ_NTEST = 4;
    localparam int LACQ_NREG = 23;
    // Register indices; byte address is index times four
    localparam logic [4:0] LACQ_CTRL = 5'h00;
    localparam logic [4:0] LACQ_WORD_LO = 5'h01;
    localparam logic [4:0] LACQ_WORD_HI = 5'h02;
    localparam logic [4:0] LACQ_CARE_LO = 5'h03;
    localparam logic [4:0] LACQ_CARE_HI = 5'h04;
    localparam logic [4:0] LACQ_POL_LO = 5'h05;
    localparam logic [4:0] LACQ_POL_HI = 5'h06;
    localparam logic [4:0] LACQ_TIMCFG = 5'h07;
    localparam logic [4:0] LACQ_TEST0 = 5'h08;
    localparam logic [4:0] LACQ_QUAL = 5'h0C;
    localparam logic [4:0] LACQ_DELAY = 5'h0D;
    localparam logic [4:0] LACQ_CNT = 5'h0E;
    localparam logic [4:0] LACQ_CLKQ = 5'h0F;
    localparam logic [4:0] LACQ_TIMCTL = 5'h10;
    localparam logic [4:0] LACQ_STATUS = 5'h11;
    localparam logic [4:0] LACQ_MASK = 5'h12;
    localparam logic [4:0] LACQ_STATE = 5'h13;
    localparam logic [4:0] LACQ_MEM_ADDR = 5'h14;
    localparam logic [4:0] LACQ_MEM_LO = 5'h15;
    localparam logic [4:0] LACQ_MEM_HI = 5'h16;
    // Control register fields
    localparam int LACQ_C_START = 0;
    localparam int LACQ_C_EXP = 1;
    localparam int LACQ_C_ASYNC = 2;
    localparam int LACQ_C_FALL = 4;
    localparam int LACQ_C_LVL_EN = 5;
    localparam int LACQ_C_LVL_POL = 6;
    localparam int LACQ_C_DLY_EN = 7;
    localparam int LACQ_C_NT_LSB = 8;
    // Status bits
    localparam int LACQ_S_TRIG = 0;
    localparam int LACQ_S_DONE = 1;
    localparam int LACQ_S_GLITCH = 2;
    // Test commands
    localparam logic [1:0] LACQ_CMD_NEXT = 2'h0;
    localparam logic [1:0] LACQ_CMD_TRIG = 2'h1;
    localparam logic [1:0] LACQ_CMD_INC = 2'h2;
    localparam logic [1:0] LACQ_CMD_CLR = 2'h3;
    // Bus responses
    localparam logic [1:0] LACQ_OKAY = 2'h0;
    localparam logic [1:0] LACQ_SLVERR = 2'h2;
    // Acquisition states
    typedef enum logic [3:0] {
        LACQ_IDLE = 4'h1,
        LACQ_ARMED = 4'h2,
        LACQ_POST = 4'h4,
        LACQ_DONE = 4'h8
    } lacq_state_t;
endpackage

// ==== rtl/lacq_word_match.sv ====
// Word recognizer with polarity, don't-care mask and registered true/false result
`timescale 1ns/1ps
module lacq_word_match #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] data,
    input wire logic [W-1:0] word,
    input wire logic [W-1:0] care,
    input wire logic [W-1:0] neg,
    output logic hit,
    output logic hit_now
);
    logic [W-1:0] logic_val;

    // Polarity map, then compare only bits marked as cared
    always_comb begin
        logic_val = data ^ neg;
        hit_now = &(~care | ~(logic_val ^ word));
    end

    // Single event output, updated on each enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hit <= 1'b0;
        end else if (en) begin
            hit <= hit_now;
        end
    end
endmodule // lacq_word_match

// ==== rtl/lacq_core.sv ====
// Acquisition and trigger core with AXI4-Lite register slave
`timescale 1ns/1ps
module lacq_core
    import lacq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [LACQ_REC_W-1:0] probe,
    input wire logic [LACQ_TIM_W-1:0] probe_tim,
    input wire logic sut_clk,
    input wire logic sut_sync,
    input wire logic sut_level,
    input wire logic [6:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [6:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rw_mask(input logic [4:0] idx);
        unique case (idx)
            LACQ_CTRL: rw_mask = 32'h000003FE;
            LACQ_WORD_HI, LACQ_CARE_HI, LACQ_POL_HI: rw_mask = 32'h00007FFF;
            LACQ_TIMCFG: rw_mask = 32'h00FFFFFF;
            LACQ_QUAL: rw_mask = 32'h0000009F;
            LACQ_DELAY: rw_mask = 32'h000001FF;
            LACQ_CNT: rw_mask = 32'h0000FFFF;
            LACQ_CLKQ, LACQ_MEM_ADDR: rw_mask = 32'h000000FF;
            LACQ_TIMCTL: rw_mask = 32'h0007FFFF;
            LACQ_MASK: rw_mask = 32'h00000007;
            LACQ_STATUS, LACQ_STATE, LACQ_MEM_LO, LACQ_MEM_HI: rw_mask = 32'h00000000;
            default: rw_mask = (idx >= LACQ_TEST0 && idx < LACQ_QUAL) ? 32'h0000007F
                : (idx < LACQ_NREG[4:0] ? 32'hFFFFFFFF : 32'h00000000);
        endcase
    endfunction

    // Event evaluation: select, AND/OR combine, optional complement
    function automatic logic evt(input logic [4:0] cfg, input logic [2:0] src);
        logic r;
        r = cfg[3] ? |(cfg[2:0] & src) : &(~cfg[2:0] | src);
        evt = r ^ cfg[4];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers and bus slave
    logic [31:0] cfg [0:LACQ_NREG-1];
    logic [4:0] aw_idx;
    logic [31:0] wr_mask;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr, rd_take, rd_status;
    logic [2:0] status, next_status, ev_set;
    logic [31:0] rd_val;
    lacq_state_t state;
    logic [LACQ_AW-1:0] wr_ptr;
    logic [8:0] post_cnt;
    logic [1:0] cur_test;
    logic [15:0] evt_cnt;
    logic [LACQ_STORE_W+LACQ_TIM_W-1:0] mem [0:LACQ_DEPTH-1];
    logic [LACQ_STORE_W+LACQ_TIM_W-1:0] mem_q;

    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_mask = rw_mask(aw_idx);
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_status = rd_take && (s_axi_araddr[6:2] == LACQ_STATUS);

    // Write address and data taken in either order, answer after both
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LACQ_OKAY;
            aw_idx <= 5'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                aw_idx <= s_axi_awaddr[6:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_idx < LACQ_NREG[4:0]) ? LACQ_OKAY : LACQ_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register array with byte strobes; read-only words stay zero here
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < LACQ_NREG; i++) begin
                cfg[i] <= 32'h00000000;
            end
        end else if (do_wr && aw_idx < LACQ_NREG[4:0]) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_q[b]) begin
                    cfg[aw_idx][8*b +: 8] <= wdata_q[8*b +: 8] & wr_mask[8*b +: 8];
                end
            end
        end
    end

    // Read mux
    always_comb begin
        unique case (s_axi_araddr[6:2])
            LACQ_STATUS: rd_val = {29'h0, status};
            LACQ_STATE: rd_val = {16'h0, wr_ptr, 2'h0, cur_test, state};
            LACQ_MEM_LO: rd_val = mem_q[31:0];
            LACQ_MEM_HI: rd_val = {12'h0, mem_q[LACQ_STORE_W+LACQ_TIM_W-1:32]};
            default: rd_val = cfg[s_axi_araddr[6:2] < LACQ_NREG[4:0] ? s_axi_araddr[6:2] : 5'h00]
                & rw_mask(s_axi_araddr[6:2]);
        endcase
    end

    // Read channel, one word in flight
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= LACQ_OKAY;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= (s_axi_araddr[6:2] < LACQ_NREG[4:0]) ? LACQ_OKAY : LACQ_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Sticky status, read clears, a new event wins over the clear
    always_comb begin
        next_status = (rd_status ? 3'h0 : status) | ev_set;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status <= 3'h0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= |(next_status & cfg[LACQ_MASK][2:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [LACQ_REC_W-1:0] probe_m, probe_s;
    logic [LACQ_TIM_W-1:0] tim_m, tim_s;
    logic [2:0] ck_m, ck_s;
    logic clk_prev, sync_prev;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            probe_m <= '0;
            probe_s <= '0;
            tim_m <= '0;
            tim_s <= '0;
            ck_m <= 3'h0;
            ck_s <= 3'h0;
            clk_prev <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            probe_m <= probe;
            probe_s <= probe_m;
            tim_m <= probe_tim;
            tim_s <= tim_m;
            ck_m <= {sut_level, sut_sync, sut_clk};
            ck_s <= ck_m;
            clk_prev <= ck_s[0];
            sync_prev <= ck_s[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State clock qualification
    logic [31:0] ctrl;
    logic edge_hit, lvl_ok, dly_ok, state_en;
    logic [7:0] dly_cnt;

    assign ctrl = cfg[LACQ_CTRL];
    assign edge_hit = ctrl[LACQ_C_FALL] ? (clk_prev && !ck_s[0]) : (!clk_prev && ck_s[0]);
    assign lvl_ok = !ctrl[LACQ_C_LVL_EN] || (ck_s[2] == ctrl[LACQ_C_LVL_POL]);
    assign dly_ok = !ctrl[LACQ_C_DLY_EN] || (dly_cnt == 8'h00);
    assign state_en = edge_hit && lvl_ok && dly_ok;

    // Preset delay in raw clock edges after the synchronizing signal rises
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dly_cnt <= 8'h00;
        end else if (ck_s[1] && !sync_prev) begin
            dly_cnt <= cfg[LACQ_CLKQ][7:0];
        end else if (edge_hit && dly_cnt != 8'h00) begin
            dly_cnt <= dly_cnt - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal time base, glitch detector and async filter
    logic async_md, tb_tick, seen, trans, glitch_evt, sample_en;
    logic [7:0] tb_cnt, filt_cnt;
    logic tim_prev;
    logic [2:0] gsel;

    assign async_md = ctrl[LACQ_C_ASYNC];
    assign gsel = cfg[LACQ_TIMCTL][18:16];
    assign trans = tim_s[gsel] ^ tim_prev;
    assign glitch_evt = async_md && trans && seen && !tb_tick;
    assign sample_en = async_md ? tb_tick : state_en;

    // Time base runs on the core clock, independent of the probed system
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tb_cnt <= 8'h00;
            tb_tick <= 1'b0;
        end else if (tb_cnt >= cfg[LACQ_TIMCTL][7:0]) begin
            tb_cnt <= 8'h00;
            tb_tick <= async_md;
        end else begin
            tb_cnt <= tb_cnt + 8'h01;
            tb_tick <= 1'b0;
        end
    end

    // Transition seen since the last tick
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tim_prev <= 1'b0;
            seen <= 1'b0;
        end else begin
            tim_prev <= tim_s[gsel];
            seen <= tb_tick ? trans : (seen || trans);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word recognizers
    logic [LACQ_REC_W-1:0] care_eff;
    logic main_hit, tim_hit, tim_now, tim_valid, cnt_hit;

    assign care_eff = {cfg[LACQ_CARE_HI][14:0], cfg[LACQ_CARE_LO]}
        & (ctrl[LACQ_C_EXP] ? {LACQ_REC_W{1'b1}} : {{(LACQ_REC_W-LACQ_BASE_REC_W){1'b0}},
        {LACQ_BASE_REC_W{1'b1}}});

    lacq_word_match #(.W(LACQ_REC_W)) u_main_match (
        .clock(clock),
        .rst(rst),
        .en(state_en),
        .data(probe_s),
        .word({cfg[LACQ_WORD_HI][14:0], cfg[LACQ_WORD_LO]}),
        .care(care_eff),
        .neg({cfg[LACQ_POL_HI][14:0], cfg[LACQ_POL_LO]}),
        .hit(main_hit),
        .hit_now()
    );

    // Timing recognizer: level sampled on state clock, or every edge in async mode
    lacq_word_match #(.W(LACQ_TIM_W)) u_tim_match (
        .clock(clock),
        .rst(rst),
        .en(async_md || state_en),
        .data(tim_s),
        .word(cfg[LACQ_TIMCFG][7:0]),
        .care(cfg[LACQ_TIMCFG][15:8]),
        .neg(cfg[LACQ_TIMCFG][23:16]),
        .hit(tim_hit),
        .hit_now(tim_now)
    );

    // Persistence filter for async matches
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filt_cnt <= 8'h00;
        end else if (!tim_hit) begin
            filt_cnt <= 8'h00;
        end else if (filt_cnt != 8'hFF) begin
            filt_cnt <= filt_cnt + 8'h01;
        end
    end

    assign tim_valid = async_md ? (tim_hit && filt_cnt >= cfg[LACQ_TIMCTL][15:8]) : tim_hit;
    assign cnt_hit = (evt_cnt == cfg[LACQ_CNT][15:0]);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, trigger and delay counter
    logic [2:0] srcs;
    logic [6:0] tcfg;
    logic test_ev, trig_fire, qual_ok, mem_wr, start, running, done_set;
    logic [LACQ_STORE_W-1:0] store_main;

    assign srcs = {cnt_hit, tim_valid, main_hit};
    assign tcfg = cfg[LACQ_TEST0 + {3'h0, cur_test}][6:0];
    assign test_ev = evt(tcfg[4:0], srcs);
    assign start = do_wr && aw_idx == LACQ_CTRL && wstrb_q[0] && wdata_q[LACQ_C_START];
    assign running = (state == LACQ_ARMED) || (state == LACQ_POST);
    assign trig_fire = sample_en && state == LACQ_ARMED && test_ev && tcfg[6:5] == LACQ_CMD_TRIG;
    assign qual_ok = !cfg[LACQ_QUAL][7] || evt(cfg[LACQ_QUAL][4:0], srcs);
    assign mem_wr = sample_en && running && qual_ok;
    assign store_main = probe_s[LACQ_STORE_W-1:0] & (ctrl[LACQ_C_EXP] ? {LACQ_STORE_W{1'b1}}
        : {{(LACQ_STORE_W-LACQ_BASE_STORE_W){1'b0}}, {LACQ_BASE_STORE_W{1'b1}}});
    // Done also flags at once when a zero delay ends acquisition on the trigger itself
    assign done_set = (state == LACQ_POST && mem_wr && post_cnt == 9'h001)
        || (trig_fire && cfg[LACQ_DELAY][8:0] == 9'h000);
    assign ev_set = {glitch_evt, done_set, trig_fire};

    // Test index and event counter advance on qualified sample clocks
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cur_test <= 2'h0;
            evt_cnt <= 16'h0000;
        end else if (start) begin
            cur_test <= 2'h0;
            evt_cnt <= 16'h0000;
        end else if (sample_en && state == LACQ_ARMED && test_ev) begin
            unique case (tcfg[6:5])
                LACQ_CMD_NEXT: begin
                    if (cur_test < ctrl[LACQ_C_NT_LSB +: 2]) begin
                        cur_test <= cur_test + 2'h1;
                    end
                end
                LACQ_CMD_INC: evt_cnt <= evt_cnt + 16'h0001;
                LACQ_CMD_CLR: evt_cnt <= 16'h0000;
                LACQ_CMD_TRIG: evt_cnt <= evt_cnt;
            endcase
        end
    end

    // Acquisition state machine
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= LACQ_IDLE;
            post_cnt <= 9'h000;
        end else if (start) begin
            state <= LACQ_ARMED;
            post_cnt <= 9'h000;
        end else begin
            unique case (state)
                LACQ_IDLE, LACQ_DONE: state <= state;
                LACQ_ARMED: begin
                    if (trig_fire) begin
                        post_cnt <= cfg[LACQ_DELAY][8:0];
                        state <= (cfg[LACQ_DELAY][8:0] == 9'h000) ? LACQ_DONE : LACQ_POST;
                    end
                end
                LACQ_POST: begin
                    if (mem_wr) begin
                        post_cnt <= post_cnt - 9'h001;
                        if (post_cnt == 9'h001) begin
                            state <= LACQ_DONE;
                        end
                    end
                end
                default: state <= LACQ_IDLE;
            endcase
        end
    end

    // Circular memory write pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= 8'h00;
        end else if (start) begin
            wr_ptr <= 8'h00;
        end else if (mem_wr) begin
            wr_ptr <= wr_ptr + 8'h01;
        end
    end

    // Sample store and registered readback
    always_ff @(posedge clock) begin
        if (mem_wr) begin
            mem[wr_ptr] <= {tim_s, store_main};
        end
        mem_q <= mem[cfg[LACQ_MEM_ADDR][7:0]];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_WRAP: assert property (@(posedge clock) disable iff (rst)
        mem_wr && !start && wr_ptr == 8'hFF |=> wr_ptr == 8'h00) else $error("pointer did not wrap");
    AST_DONE: assert property (@(posedge clock) disable iff (rst)
        state == LACQ_POST && mem_wr && post_cnt == 9'h001 && !start |=> state == LACQ_DONE && status[LACQ_S_DONE])
        else $error("done not reached at zero count");
    AST_TRIG: assert property (@(posedge clock) disable iff (rst)
        trig_fire && !start |=> state != LACQ_ARMED && status[LACQ_S_TRIG]) else $error("trigger ignored");
    AST_QUAL: assert property (@(posedge clock) disable iff (rst)
        mem_wr |-> qual_ok && running) else $error("unqualified store");
    AST_SCLK: assert property (@(posedge clock) disable iff (rst)
        mem_wr && !async_md |-> edge_hit && lvl_ok && dly_ok) else $error("store off state clock");
    AST_GLITCH: assert property (@(posedge clock) disable iff (rst)
        glitch_evt |=> status[LACQ_S_GLITCH]) else $error("glitch not flagged");
    AST_FILT: assert property (@(posedge clock) disable iff (rst)
        async_md && tim_valid |-> $past(tim_now, 2) || cfg[LACQ_TIMCTL][15:8] == 8'h00)
        else $error("short match passed filter");
    AST_EXP: assert property (@(posedge clock) disable iff (rst)
        mem_wr && !ctrl[LACQ_C_EXP] |-> store_main[LACQ_STORE_W-1:LACQ_BASE_STORE_W] == '0)
        else $error("base mode stored expansion bits");
    AST_IRQ: assert property (@(posedge clock) disable iff (rst)
        ##1 irq == |(status & $past(cfg[LACQ_MASK][2:0]))) else $error("interrupt level wrong");
endmodule // lacq_core

// ==== tb/lacq_sut.sv ====
// Behavioural system under test driving the probed channels
`timescale 1ns/1ps
module lacq_sut (
    output logic sut_clk,
    output logic sut_sync,
    output logic sut_level,
    output logic [46:0] probe,
    output logic [7:0] probe_tim
);
    assign sut_sync = 1'b0;
    assign sut_level = ~probe[0]; // High on even samples, used by level qualification
    // Free-running target clock of 200 ns; data changes on the falling edge, stable at the rising one
    initial begin
        sut_clk = 1'b0;
        probe = 47'h0;
        probe_tim = 8'h0;
    end
    always #100 sut_clk = ~sut_clk;
    always @(negedge sut_clk) begin
        probe <= probe + 47'h1;
        probe_tim <= probe_tim + 8'h1;
    end
endmodule // lacq_sut

// ==== tb/testbench.sv ====
// Register-level testbench of the acquisition core
`timescale 1ns/1ps
module testbench;
    import lacq_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic sut_clk, sut_sync, sut_level, irq;
    logic [46:0] probe;
    logic [7:0] probe_tim;
    logic [6:0] awaddr = 7'h00, araddr = 7'h00;
    logic [31:0] wdata = 32'h0, rd_data, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_resp;
    int errors = 0, num_checks = 0, n, p;
    logic [7:0] ptr;
    always #12.5 clock = ~clock;
    lacq_sut sut (.sut_clk(sut_clk), .sut_sync(sut_sync), .sut_level(sut_level), .probe(probe), .probe_tim(probe_tim));
    lacq_core dut (.clock(clock), .rst(rst), .probe(probe), .probe_tim(probe_tim), .sut_clk(sut_clk),
        .sut_sync(sut_sync), .sut_level(sut_level), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // AXI4-Lite write of one word at a register index
    task automatic wr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge clock);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1 && !awvalid && !wvalid) break;
        end
        bready <= 1'b0;
        if (n == 100) begin
            errors++;
            end_of_test();
        end
        chk("bresp", {30'h0, LACQ_OKAY}, {30'h0, bresp});
    endtask
    // AXI4-Lite read of one word at a register index
    task automatic rd(input logic [4:0] idx);
        @(posedge clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1 && !arvalid) break;
        end
        rready <= 1'b0;
        rd_data = rdata;
        rd_resp = rresp;
        if (n == 100) begin
            errors++;
            end_of_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        // Control register reset value, unmapped index and mask read-back
        rd(LACQ_CTRL);
        chk("ctrl reset", 32'h0, rd_data);
        rd(5'h17);
        chk("unmapped resp", {30'h0, LACQ_SLVERR}, {30'h0, rd_resp});
        chk("unmapped data", 32'h0, rd_data);
        wr(LACQ_MASK, 32'h2);
        rd(LACQ_MASK);
        chk("mask", 32'h2, rd_data);
        $display("test registers done");
        // Trigger on a masked word in both polarities, then run the post-trigger delay out;
        // the second pass samples on falling edges with the level qualifier keeping even samples
        for (p = 0; p < 2; p++) begin
            wr(LACQ_WORD_LO, p ? 32'h0000_00EF : 32'h0000_0010);
            wr(LACQ_CARE_LO, 32'h0000_00FF);
            wr(LACQ_POL_LO, p ? 32'h0000_00FF : 32'h0);
            wr(LACQ_TEST0, 32'h0000_0021);
            wr(LACQ_DELAY, 32'h3);
            wr(LACQ_CTRL, p ? 32'h71 : 32'h1);
            for (int k = 0; k < 2000; k++) begin
                rd(LACQ_STATE);
                if (rd_data[3:0] === 4'h8) break;
            end
            chk("state done", 32'h8, {28'h0, rd_data[3:0]});
            ptr = rd_data[15:8];
            chk("irq set", 32'h1, {31'h0, irq});
            rd(LACQ_STATUS);
            chk("status", 32'h3, rd_data);
            rd(LACQ_STATUS);
            chk("status cleared", 32'h0, rd_data);
            repeat (2) @(posedge clock);
            chk("irq clear", 32'h0, {31'h0, irq});
            // Five newest words: the matching one, the trigger sample and three after it
            for (int j = 1; j < 6; j++) begin
                wr(LACQ_MEM_ADDR, {24'h0, ptr - j[7:0]});
                rd(LACQ_MEM_LO);
                chk("mem lo", 32'h10 + (p + 1) * (5 - j), rd_data & 32'hFF);
                rd(LACQ_MEM_HI);
                chk("mem hi", (32'h10 + (p + 1) * (5 - j)) << 12, rd_data);
            end
            $display("test trigger polarity %0d done", p);
        end
        // Timing channel 0 toggles four times per slow tick in async mode; filter needs four cycles
        wr(LACQ_TIMCTL, 32'h0000041F);
        wr(LACQ_CTRL, 32'h5);
        repeat (100) @(posedge clock);
        rd(LACQ_STATUS);
        chk("glitch", 32'h4, rd_data & 32'h4);
        $display("test glitch done");
        end_of_test();
    end
endmodule // testbench
